/* common/ltsr_consts.vh */
// Constants for the logic timer and set/reset latch block.
`ifndef LTSR_CONSTS_VH
`define LTSR_CONSTS_VH

// ****************************************************************
// Time base
// ****************************************************************
`define LTSR_CLK_HZ          25000000
`define LTSR_SAMPLE_MS       8
`define LTSR_TENTH_MS        100
`define LTSR_SAMPLE_CYC      (`LTSR_CLK_HZ / 1000 * `LTSR_SAMPLE_MS)
`define LTSR_TENTH_CYC       (`LTSR_CLK_HZ / 1000 * `LTSR_TENTH_MS)
`define LTSR_TIME_W          19
`define LTSR_TIME_MAX        19'h57e3f

// ****************************************************************
// Mode encodings
// ****************************************************************
`define LTSR_MODE_OFF        2'h0
`define LTSR_MODE_DELAY      2'h1
`define LTSR_MODE_ALT        2'h2
`define LTSR_MODE_ONTIME     2'h3
`define LTSR_PRIO_CLEAR      2'h0
`define LTSR_PRIO_SET        2'h1
`define LTSR_PRIO_EDGE       2'h2

// ****************************************************************
// Register map
// ****************************************************************
`define LTSR_TMR_BASE        8'h00
`define LTSR_LAT_BASE        8'h40
`define LTSR_TVAL_BASE       8'h80
`define LTSR_OFS_CFG         8'h00
`define LTSR_OFS_A           8'h04
`define LTSR_OFS_B           8'h08
`define LTSR_OFS_C           8'h0c
`define LTSR_LOGIC_CDLY      8'h90
`define LTSR_LOGIC_VAL       8'h94
`define LTSR_STATUS          8'h98

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define LTSR_CFG_MODE_LSB    0
`define LTSR_CFG_SRC_A_LSB   8
`define LTSR_CFG_SRC_B_LSB   16
`define LTSR_SRC_W           6
`define LTSR_TMR_MODE_RST    2'h1
`define LTSR_LAT_PRIO_RST    8'h90
`define LTSR_SRC_RST         6'h00
`define LTSR_TIME_RST        19'h00000

`endif

/* core/ltsr_timer.v */
// One tenth-second timer stage with off, delay, alternate and on-time behaviour.
`timescale 1ns/100ps
`include "ltsr_consts.vh"

module ltsr_timer #(
    parameter TW = `LTSR_TIME_W
) (
    // Clock and reset.
    input  wire          pclk,
    input  wire          presetn,
    input  wire          ce,
    // Time base and trigger.
    input  wire          tick,
    input  wire          trig,
    // Settings.
    input  wire [1:0]    mode,
    input  wire [TW-1:0] dly,
    input  wire [TW-1:0] t_on,
    input  wire [TW-1:0] t_off,
    // Result.
    output reg           out_q,
    output reg  [TW-1:0] cnt_q
);

    reg phase_q;

    // ****************************************************************
    // Mode engine
    // ****************************************************************
    // Settings are read live, so a change of mode or time never clears the count.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q   <= 1'b0;
            cnt_q   <= {TW{1'b0}};
            phase_q <= 1'b0;
        end else if (ce) begin // R10
            case (mode)
                `LTSR_MODE_DELAY: begin
                    if (!trig) begin
                        out_q <= 1'b0; // R6
                        cnt_q <= {TW{1'b0}};
                    end else if (cnt_q >= dly) begin
                        out_q <= 1'b1; // R5
                    end else if (tick) begin
                        cnt_q <= cnt_q + {{(TW-1){1'b0}}, 1'b1}; // R23
                    end
                end
                `LTSR_MODE_ALT: begin
                    if (!trig) begin
                        out_q   <= 1'b0; // R8
                        cnt_q   <= {TW{1'b0}};
                        phase_q <= 1'b0;
                    end else begin
                        out_q <= !phase_q; // R7
                        if (cnt_q >= (phase_q ? t_off : t_on)) begin
                            phase_q <= !phase_q;
                            cnt_q   <= {TW{1'b0}};
                        end else if (tick) begin
                            cnt_q <= cnt_q + {{(TW-1){1'b0}}, 1'b1};
                        end
                    end
                end
                `LTSR_MODE_ONTIME: begin
                    if (trig) begin
                        out_q <= 1'b1; // R9
                        cnt_q <= {TW{1'b0}};
                    end else if (out_q) begin
                        if (cnt_q >= t_on) begin
                            out_q <= 1'b0;
                        end else if (tick) begin
                            cnt_q <= cnt_q + {{(TW-1){1'b0}}, 1'b1};
                        end
                    end
                end
                default: begin
                    out_q <= 1'b0;
                end
            endcase
        end
    end

endmodule

/* core/ltsr_top.v */
// Logic timers, delayed set/reset latches and logic output clear delay behind APB.
// Contract
// R1 - Logic output stays high for the clear delay after the result falls; default zero.
// R2 - Running count of the logic output clear delay is readable.
// R3 - Timer mode: 0 off, 1 delay, 2 alternate, 3 on-time; default delay.
// R4 - Each timer has a trigger source, default off; an active trigger starts it.
// R5 - Delay mode: output rises after trigger held for the delay time.
// R6 - Delay mode: output drops at once when the trigger goes low.
// R7 - Alternate mode: output cycles on interval high, off interval low while triggered.
// R8 - Alternate mode: output forced low once the trigger goes low.
// R9 - On-time mode: output held high beyond the trigger for the on interval.
// R10 - Changing mode or times keeps the running timer count.
// R11 - Each timer's elapsed count is readable.
// R12 - Four identical timers, each with own settings and output.
// R13 - Latch holds its output when set and clear are both inactive.
// R14 - Set alone gives 1, clear alone gives 0.
// R15 - Clear priority: both active gives 0.
// R16 - Set priority: both active gives 1.
// R17 - Edge mode: rising set gives 1, rising clear gives 0, latest wins.
// R18 - Edge mode: both edges in one sample keep the output.
// R19 - Latch inputs sampled on an 8 ms tick; closer changes are simultaneous.
// R20 - Priority: 0 clear, 1 set, 2 edge; set and clear sources default off.
// R21 - Set input delayed by a programmable time, default zero.
// R22 - Clear input delayed by a programmable time, default zero.
// R23 - All delays count a common tenth-second tick against the programmed value.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "ltsr_consts.vh"

module ltsr_top #(
    parameter SRC_N      = 48,
    parameter SAMPLE_CYC = `LTSR_SAMPLE_CYC,
    parameter TENTH_CYC  = `LTSR_TENTH_CYC
) (
    // Clock, reset and enable.
    input  wire             pclk,
    input  wire             presetn,
    input  wire             ce,
    // APB slave.
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [7:0]       paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output wire             pready,
    output reg              pslverr,
    // Selectable source signals.
    input  wire [SRC_N-1:0] src_in,
    // Logic function result and its delayed output.
    input  wire             logic_result,
    output wire             logic_out,
    // Timer and latch outputs.
    output wire [3:0]       timer_out,
    output reg  [3:0]       latch_out
);

    localparam TW = `LTSR_TIME_W;
    localparam SW = `LTSR_SRC_W;
    localparam [7:0] PRIO_RST = `LTSR_LAT_PRIO_RST;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Source 0 is off; source n selects input n-1.
    function src_pick;
        input [SRC_N-1:0] v;
        input [SW-1:0]    s;
        begin
            src_pick = (s == {SW{1'b0}} || {26'h0, s} > SRC_N) ? 1'b0 : v[s - 6'h01];
        end
    endfunction

    function [7:0] reg_addr;
        input [7:0] base;
        input [1:0] idx;
        input [7:0] ofs;
        begin
            reg_addr = base + {2'h0, idx, 4'h0} + ofs;
        end
    endfunction

    // ****************************************************************
    // Setting storage
    // ****************************************************************
    reg [1:0]    timer_mode_select_q    [0:3];
    reg [SW-1:0] timer_trigger_source_q [0:3];
    reg [TW-1:0] timer_delay_time_q     [0:3];
    reg [TW-1:0] on_interval_time_q     [0:3];
    reg [TW-1:0] off_interval_time_q    [0:3];
    reg [1:0]    latch_priority_select_q[0:3];
    reg [SW-1:0] latch_set_source_q     [0:3];
    reg [SW-1:0] latch_clear_source_q   [0:3];
    reg [TW-1:0] latch_set_delay_q      [0:3];
    reg [TW-1:0] latch_clear_delay_q    [0:3];
    reg [TW-1:0] logic_output_clear_delay_q;

    wire [TW-1:0] timer_cnt     [0:3];
    wire [TW-1:0] set_dly_cnt   [0:3];
    wire [3:0]    set_dly_out;
    wire [3:0]    clr_dly_out;
    wire [TW-1:0] logic_cnt;

    // ****************************************************************
    // Time base
    // ****************************************************************
    reg  [31:0]      sample_cnt_q;
    reg  [31:0]      tenth_cnt_q;
    reg              sample_tick_q;
    reg              tenth_tick_q;
    reg  [SRC_N-1:0] src_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_cnt_q  <= 32'h0;
            tenth_cnt_q   <= 32'h0;
            sample_tick_q <= 1'b0;
            tenth_tick_q  <= 1'b0;
            src_q         <= {SRC_N{1'b0}};
        end else if (ce) begin
            sample_tick_q <= (sample_cnt_q == SAMPLE_CYC - 1);
            tenth_tick_q  <= (tenth_cnt_q == TENTH_CYC - 1); // R23
            sample_cnt_q  <= (sample_cnt_q == SAMPLE_CYC - 1) ? 32'h0 : sample_cnt_q + 32'h1;
            tenth_cnt_q   <= (tenth_cnt_q == TENTH_CYC - 1) ? 32'h0 : tenth_cnt_q + 32'h1;
            if (sample_cnt_q == SAMPLE_CYC - 1) begin
                src_q <= src_in; // R19
            end
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Read data and error are captured in the setup cycle; the access cycle is stretched only while ce is low.
    reg  [31:0] rd_d;
    reg         hit_d;
    wire        wr_en;
    integer     ri;
    integer     wi;

    assign pready = ce;
    assign wr_en  = psel & penable & pwrite & ce;

    always @* begin
        rd_d  = 32'h0;
        hit_d = 1'b0;
        for (ri = 0; ri < 4; ri = ri + 1) begin
            if (paddr == reg_addr(`LTSR_TMR_BASE, ri[1:0], `LTSR_OFS_CFG)) begin
                rd_d  = {18'h0, timer_trigger_source_q[ri], 6'h0, timer_mode_select_q[ri]};
                hit_d = 1'b1;
            end
            if (paddr == reg_addr(`LTSR_TMR_BASE, ri[1:0], `LTSR_OFS_A)) begin
                rd_d  = {13'h0, timer_delay_time_q[ri]};
                hit_d = 1'b1;
            end
            if (paddr == reg_addr(`LTSR_TMR_BASE, ri[1:0], `LTSR_OFS_B)) begin
                rd_d  = {13'h0, on_interval_time_q[ri]};
                hit_d = 1'b1;
            end
            if (paddr == reg_addr(`LTSR_TMR_BASE, ri[1:0], `LTSR_OFS_C)) begin
                rd_d  = {13'h0, off_interval_time_q[ri]};
                hit_d = 1'b1;
            end
            if (paddr == reg_addr(`LTSR_LAT_BASE, ri[1:0], `LTSR_OFS_CFG)) begin
                rd_d  = {10'h0, latch_clear_source_q[ri], 2'h0, latch_set_source_q[ri],
                         6'h0, latch_priority_select_q[ri]};
                hit_d = 1'b1;
            end
            if (paddr == reg_addr(`LTSR_LAT_BASE, ri[1:0], `LTSR_OFS_A)) begin
                rd_d  = {13'h0, latch_set_delay_q[ri]};
                hit_d = 1'b1;
            end
            if (paddr == reg_addr(`LTSR_LAT_BASE, ri[1:0], `LTSR_OFS_B)) begin
                rd_d  = {13'h0, latch_clear_delay_q[ri]};
                hit_d = 1'b1;
            end
            if (paddr == reg_addr(`LTSR_LAT_BASE, ri[1:0], `LTSR_OFS_C)) begin
                rd_d  = {13'h0, set_dly_cnt[ri]};
                hit_d = 1'b1;
            end
            if (paddr == `LTSR_TVAL_BASE + {4'h0, ri[1:0], 2'h0}) begin
                rd_d  = {13'h0, timer_cnt[ri]}; // R11
                hit_d = 1'b1;
            end
        end
        if (paddr == `LTSR_LOGIC_CDLY) begin
            rd_d  = {13'h0, logic_output_clear_delay_q};
            hit_d = 1'b1;
        end
        if (paddr == `LTSR_LOGIC_VAL) begin
            rd_d  = {13'h0, logic_cnt}; // R2
            hit_d = 1'b1;
        end
        if (paddr == `LTSR_STATUS) begin
            rd_d  = {23'h0, logic_out, latch_out, timer_out};
            hit_d = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (ce && psel && !penable) begin
            prdata  <= pwrite ? 32'h0 : rd_d;
            pslverr <= !hit_d;
        end
    end

    // Writes never touch the running counts, so a new setting takes over mid-count.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (wi = 0; wi < 4; wi = wi + 1) begin
                timer_mode_select_q[wi]     <= `LTSR_TMR_MODE_RST; // R3
                timer_trigger_source_q[wi]  <= `LTSR_SRC_RST; // R4
                timer_delay_time_q[wi]      <= `LTSR_TIME_RST;
                on_interval_time_q[wi]      <= `LTSR_TIME_RST;
                off_interval_time_q[wi]     <= `LTSR_TIME_RST;
                latch_priority_select_q[wi] <= PRIO_RST[2 * wi +: 2]; // R20
                latch_set_source_q[wi]      <= `LTSR_SRC_RST;
                latch_clear_source_q[wi]    <= `LTSR_SRC_RST;
                latch_set_delay_q[wi]       <= `LTSR_TIME_RST;
                latch_clear_delay_q[wi]     <= `LTSR_TIME_RST;
            end
            logic_output_clear_delay_q <= `LTSR_TIME_RST;
        end else if (wr_en) begin // R10
            for (wi = 0; wi < 4; wi = wi + 1) begin
                if (paddr == reg_addr(`LTSR_TMR_BASE, wi[1:0], `LTSR_OFS_CFG)) begin
                    timer_mode_select_q[wi]    <= pwdata[`LTSR_CFG_MODE_LSB +: 2];
                    timer_trigger_source_q[wi] <= pwdata[`LTSR_CFG_SRC_A_LSB +: SW];
                end
                if (paddr == reg_addr(`LTSR_TMR_BASE, wi[1:0], `LTSR_OFS_A)) begin
                    timer_delay_time_q[wi] <= pwdata[TW-1:0];
                end
                if (paddr == reg_addr(`LTSR_TMR_BASE, wi[1:0], `LTSR_OFS_B)) begin
                    on_interval_time_q[wi] <= pwdata[TW-1:0];
                end
                if (paddr == reg_addr(`LTSR_TMR_BASE, wi[1:0], `LTSR_OFS_C)) begin
                    off_interval_time_q[wi] <= pwdata[TW-1:0];
                end
                if (paddr == reg_addr(`LTSR_LAT_BASE, wi[1:0], `LTSR_OFS_CFG)) begin
                    latch_priority_select_q[wi] <= pwdata[`LTSR_CFG_MODE_LSB +: 2];
                    latch_set_source_q[wi]      <= pwdata[`LTSR_CFG_SRC_A_LSB +: SW];
                    latch_clear_source_q[wi]    <= pwdata[`LTSR_CFG_SRC_B_LSB +: SW];
                end
                if (paddr == reg_addr(`LTSR_LAT_BASE, wi[1:0], `LTSR_OFS_A)) begin
                    latch_set_delay_q[wi] <= pwdata[TW-1:0];
                end
                if (paddr == reg_addr(`LTSR_LAT_BASE, wi[1:0], `LTSR_OFS_B)) begin
                    latch_clear_delay_q[wi] <= pwdata[TW-1:0];
                end
            end
            if (paddr == `LTSR_LOGIC_CDLY) begin
                logic_output_clear_delay_q <= pwdata[TW-1:0];
            end
        end
    end

    // ****************************************************************
    // Timers and input delays
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_unit
            ltsr_timer #(.TW(TW)) u_timer (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .tick    (tenth_tick_q),
                .trig    (src_pick(src_q, timer_trigger_source_q[g])), // R4
                .mode    (timer_mode_select_q[g]),
                .dly     (timer_delay_time_q[g]),
                .t_on    (on_interval_time_q[g]),
                .t_off   (off_interval_time_q[g]),
                .out_q   (timer_out[g]), // R12
                .cnt_q   (timer_cnt[g])
            );
            ltsr_timer #(.TW(TW)) u_set_dly (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .tick    (tenth_tick_q),
                .trig    (src_pick(src_q, latch_set_source_q[g])),
                .mode    (`LTSR_MODE_DELAY), // R21
                .dly     (latch_set_delay_q[g]),
                .t_on    (`LTSR_TIME_RST),
                .t_off   (`LTSR_TIME_RST),
                .out_q   (set_dly_out[g]),
                .cnt_q   (set_dly_cnt[g])
            );
            ltsr_timer #(.TW(TW)) u_clr_dly (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .tick    (tenth_tick_q),
                .trig    (src_pick(src_q, latch_clear_source_q[g])),
                .mode    (`LTSR_MODE_DELAY), // R22
                .dly     (latch_clear_delay_q[g]),
                .t_on    (`LTSR_TIME_RST),
                .t_off   (`LTSR_TIME_RST),
                .out_q   (clr_dly_out[g]),
                .cnt_q   ()
            );
        end
    endgenerate

    // The clear delay is an on-time stretch of the logic result.
    ltsr_timer #(.TW(TW)) u_logic_dly (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .tick    (tenth_tick_q),
        .trig    (logic_result),
        .mode    (`LTSR_MODE_ONTIME), // R1
        .dly     (`LTSR_TIME_RST),
        .t_on    (logic_output_clear_delay_q),
        .t_off   (`LTSR_TIME_RST),
        .out_q   (logic_out),
        .cnt_q   (logic_cnt)
    );

    // ****************************************************************
    // Set/reset latches
    // ****************************************************************
    // Evaluated once per sample tick, so edges within one period count as simultaneous.
    reg [3:0] set_prev_q;
    reg [3:0] clr_prev_q;
    integer   li;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_out  <= 4'h0;
            set_prev_q <= 4'h0;
            clr_prev_q <= 4'h0;
        end else if (ce && sample_tick_q) begin // R19
            set_prev_q <= set_dly_out;
            clr_prev_q <= clr_dly_out;
            for (li = 0; li < 4; li = li + 1) begin
                case (latch_priority_select_q[li])
                    `LTSR_PRIO_SET: begin
                        if (set_dly_out[li]) begin
                            latch_out[li] <= 1'b1; // R16
                        end else if (clr_dly_out[li]) begin
                            latch_out[li] <= 1'b0; // R14
                        end
                    end
                    `LTSR_PRIO_EDGE: begin
                        if (set_dly_out[li] && !set_prev_q[li] && !(clr_dly_out[li] && !clr_prev_q[li])) begin
                            latch_out[li] <= 1'b1; // R17
                        end else if (clr_dly_out[li] && !clr_prev_q[li] && !(set_dly_out[li] && !set_prev_q[li])) begin
                            latch_out[li] <= 1'b0; // R17
                        end
                    end // R18
                    default: begin
                        if (clr_dly_out[li]) begin
                            latch_out[li] <= 1'b0; // R15
                        end else if (set_dly_out[li]) begin
                            latch_out[li] <= 1'b1; // R14
                        end
                    end // R13
                endcase
            end
        end
    end

endmodule

/* verification/ltsr_top_properties.sv */
// Port-level assertions for the logic timer and latch block.
`timescale 1ns/100ps
module ltsr_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        ce,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        logic_result,
    input wire        logic_out,
    input wire [3:0]  timer_out,
    input wire [3:0]  latch_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    ready_is_ce_a: assert property (pready == ce)
        else $error("pready differs from ce");
    status_word_a: assert property (acc && !pwrite && paddr == 8'h98 && ce && $past(ce) |->
        prdata[8:0] == {$past(logic_out), $past(latch_out), $past(timer_out)}) else $error("status word wrong");
    unmapped_err_a: assert property (acc && paddr == 8'hfc |-> pslverr)
        else $error("no error on unmapped address");
    mapped_ok_a: assert property (acc && paddr == 8'h98 |-> !pslverr)
        else $error("error on status address");
    write_zero_a: assert property (acc && pwrite |-> prdata == 32'h0)
        else $error("read data not zero on write");
    logic_set_a: assert property (logic_result && ce |=> logic_out)
        else $error("logic output low while result high");
    logic_cause_a: assert property ($rose(logic_out) |-> $past(logic_result))
        else $error("logic output rose without result");
    latch_pace_a: assert property (!$stable(latch_out) |=> $stable(latch_out) [*6])
        else $error("latch output changed between sample ticks");
    freeze_all_a: assert property (!ce |=> $stable(latch_out) && $stable(timer_out) && $stable(logic_out))
        else $error("state moved while clock enable low");
endmodule

bind ltsr_top ltsr_checker u_checker (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .logic_result, .logic_out, .timer_out, .latch_out);

/* verification/test_logic_timers_and_sr_latches.sv */
// Self-checking bench for the logic timer and latch block.
`timescale 1ns/100ps
module test_logic_timers_and_sr_latches;
    localparam        SC = 8;
    localparam        TC = 20;
    localparam [13:0] PAT = 14'b11_10_11_00_10_00_01;
    localparam [27:0] EXP = 28'hc0400dd;
    reg               pclk = 1'b0;
    reg               presetn = 1'b0;
    reg               ce = 1'b1;
    reg               psel = 1'b0;
    reg               penable = 1'b0;
    reg               pwrite = 1'b0;
    reg  [7:0]        paddr = 8'h00;
    reg  [31:0]       pwdata = 32'h0;
    reg  [47:0]       src_in = 48'h0;
    reg               logic_result = 1'b0;
    wire [31:0]       prdata;
    wire              pready;
    wire              pslverr;
    wire              logic_out;
    wire [3:0]        timer_out;
    wire [3:0]        latch_out;
    reg  [31:0]       rd;
    reg               err;
    integer           num_errors = 0;
    integer           checks_done = 0;
    integer           n;
    integer           k;

    ltsr_top #(.SRC_N(48), .SAMPLE_CYC(SC), .TENTH_CYC(TC)) DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .src_in, .logic_result, .logic_out, .timer_out, .latch_out);

    always #20 pclk = ~pclk;

    task cyc(input integer c);
        repeat (c) @(posedge pclk);
    endtask

    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            psel    <= 1'b1;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task chk(input string what, input [31:0] e, input [31:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== e) begin
                num_errors = num_errors + 1;
                $display("ERROR %0s expected %h seen %h", what, e, got);
            end
        end
    endtask

    task rdc(input [7:0] a, input [31:0] e, input string what);
        begin
            apb(1'b0, a, 32'h0);
            chk(what, e, rd);
        end
    endtask

    task summarize;
        begin
            $display("checks %0d errors %0d", checks_done, num_errors);
            if (num_errors == 0 && checks_done > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    initial begin
        #(40 * 10000);
        num_errors = num_errors + 1;
        summarize;
    end

    initial begin
        cyc(6);
        presetn <= 1'b1;
        cyc(1);
        rdc(8'h00, 32'h1, "timer_cfg");
        rdc(8'h60, 32'h1, "latch2_cfg");
        rdc(8'h70, 32'h2, "latch3_cfg");
        rdc(8'h44, 32'h0, "set_delay");
        rdc(8'h48, 32'h0, "clear_delay");
        rdc(8'h90, 32'h0, "logic_delay");
        apb(1'b0, 8'hfc, 32'h0);
        chk("unmapped_err", 32'h1, err);
        $display("defaults done");
        apb(1'b1, 8'h00, 32'h0101);
        apb(1'b1, 8'h04, 32'h3);
        src_in[0] <= 1'b1;
        cyc(35);
        chk("delay_early", 32'h0, timer_out[0]);
        cyc(55);
        chk("delay_done", 32'h1, timer_out[0]);
        src_in[0] <= 1'b0;
        cyc(SC + 3);
        chk("delay_drop", 32'h0, timer_out[0]);
        apb(1'b1, 8'h10, 32'h0202);
        apb(1'b1, 8'h18, 32'h2);
        apb(1'b1, 8'h1c, 32'h2);
        src_in[1] <= 1'b1;
        n = 0;
        repeat (200) begin
            @(posedge pclk);
            n = n + timer_out[1];
        end
        chk("alt_duty", 32'h1, n > 40 && n < 160);
        src_in[1] <= 1'b0;
        cyc(SC + 3);
        chk("alt_off", 32'h0, timer_out[1]);
        apb(1'b1, 8'h20, 32'h0303);
        apb(1'b1, 8'h28, 32'h3);
        src_in[2] <= 1'b1;
        cyc(16);
        src_in[2] <= 1'b0;
        cyc(20);
        chk("ontime_stretch", 32'h1, timer_out[2]);
        cyc(100);
        chk("ontime_end", 32'h0, timer_out[2]);
        rdc(8'h88, 32'h3, "ontime_count");
        apb(1'b1, 8'h20, 32'h0300);
        src_in[2] <= 1'b1;
        cyc(SC + 3);
        chk("mode_off", 32'h0, timer_out[2]);
        rdc(8'h88, 32'h3, "count_kept");
        $display("timers done");
        apb(1'b1, 8'h40, 32'h00050400);
        apb(1'b1, 8'h60, 32'h00050401);
        apb(1'b1, 8'h70, 32'h00050402);
        for (k = 0; k < 7; k = k + 1) begin
            src_in[4:3] <= PAT[k*2 +: 2];
            cyc(3 * SC);
            chk("latch_step", EXP[k*4 +: 4], latch_out);
        end
        ce <= 1'b0;
        src_in[4:3] <= 2'b10;
        cyc(3 * SC);
        chk("latch_frozen", 32'hc, latch_out);
        ce <= 1'b1;
        cyc(3 * SC);
        chk("latch_edge_hold", 32'h8, latch_out);
        apb(1'b1, 8'h44, 32'h2);
        apb(1'b1, 8'h48, 32'h2);
        src_in[4:3] <= 2'b01;
        cyc(15);
        chk("set_dly_wait", 32'h0, latch_out[0]);
        cyc(70);
        chk("set_dly_done", 32'h1, latch_out[0]);
        src_in[4:3] <= 2'b10;
        cyc(15);
        chk("clr_dly_wait", 32'h1, latch_out[0]);
        cyc(70);
        chk("clr_dly_done", 32'h0, latch_out[0]);
        $display("latches done");
        apb(1'b1, 8'h90, 32'h2);
        logic_result <= 1'b1;
        cyc(3);
        chk("logic_on", 32'h1, logic_out);
        logic_result <= 1'b0;
        cyc(15);
        chk("logic_hold", 32'h1, logic_out);
        cyc(50);
        chk("logic_clear", 32'h0, logic_out);
        rdc(8'h94, 32'h2, "logic_count");
        rdc(8'h98, 32'h0, "status");
        $display("logic delay done");
        summarize;
    end
endmodule
